// ### dv/pvb_host_model.sv
// Host model: lamp request and brightness bus writer
`timescale 1ns/1ps
module pvb_host_model
(
  input wire logic core_clk,
  input wire logic sda_wire, // Resolved data line, pulled up
  output logic scl, // Bus clock, stands high between frames
  output logic sda_pull, // High pulls data low
  output logic on_req // Lamp request
);
  // Defined idle levels from time zero
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
    on_req = 1'b0;
  end
  // ----------------------------------------------------------------
  // Raster source: the lamp request is gated on this running
  // ----------------------------------------------------------------
  localparam int LINE_TOTAL_CLOCKS = 1344;
  localparam int LINE_ACTIVE_CLOCKS = 1024;
  localparam int FRAME_TOTAL_LINES = 806;
  localparam int FRAME_ACTIVE_LINES = 768;
  logic pixel_clock = 1'b0; // Nominal 65 MHz pixel rate
  logic active_video_strobe = 1'b0; // Frames pixel data, low in blanking
  logic video_ok = 1'b0; // Raster has begun framing pixels
  int pix_x = 0; // Clock within the line
  int pix_y = 0; // Line within the frame
  always #7.692 pixel_clock = ~pixel_clock;
  // Free-running raster; it never stops, so video stays valid all run
  always @(posedge pixel_clock)
  begin
    if (pix_x == LINE_TOTAL_CLOCKS - 1)
    begin
      pix_x <= 0;
      pix_y <= (pix_y == FRAME_TOTAL_LINES - 1) ? 0 : pix_y + 1;
    end
    else
      pix_x <= pix_x + 1;
    active_video_strobe <= (pix_x < LINE_ACTIVE_CLOCKS)
                        && (pix_y < FRAME_ACTIVE_LINES);
    if (active_video_strobe)
      video_ok <= 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  // Only raised once video is valid, dropped before it goes
  task automatic set_on(input logic v);
    on_req = v && video_ok;
  endtask : set_on
  // One bit: quarter periods of two core cycles give a 160 ns bus clock
  task automatic bit_io(input logic b, output logic rd);
    tick(2);
    sda_pull = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    rd = sda_wire;
    tick(2);
    scl = 1'b0;
  endtask : bit_io
  // Byte MSB first, then the acknowledge slot with the line released
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : send
  // Start, address, command, data, stop
  task automatic write(input logic [6:0] adr, input logic [7:0] code, output logic [2:0] acks);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
    send({adr, 1'b0}, acks[2]);
    send(8'h00, acks[1]);
    send(code, acks[0]);
    tick(2);
    sda_pull = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_pull = 1'b0;
    tick(4);
  endtask : write
endmodule : pvb_host_model

// ### dv/pvb_inv_chk.sv
// Port checker for the backlight inverter controller
`timescale 1ns/1ps
`include "pvb_defines.svh"
module pvb_inv_chk
#(
  parameter int IGNITE_CYC = 2000,
  parameter int BURST_CYC = 512
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic backlight_on_ctrl,
  input wire logic lamp_sense,
  input wire logic brightness_bus_clock,
  input wire logic brightness_bus_data_in,
  input wire logic [2:0] step_sel,
  input wire logic brightness_bus_data_out,
  input wire logic brightness_bus_data_oe,
  input wire logic lamp_drive,
  input wire logic lamp_status,
  input wire logic ignite_fault,
  input wire logic [7:0] step_code,
  input wire logic [7:0] bright_code
);
  // ----
  // Helpers
  // ----
  localparam logic [63:0] STEPS = `PVB_STEP_TABLE; // Dimmest first
  localparam int STRIKE_MAX = IGNITE_CYC + 8; // Slack covers the pin synchronisers
  logic [31:0] dark_cnt_ff; // Cycles requested on but never lit
  logic [31:0] nxt_dark_cnt;
  // Counts only while the lamp is asked for and shows no current
  always_comb
  begin
    nxt_dark_cnt = 32'h0;
    if (backlight_on_ctrl && !lamp_sense && !lamp_status && !ignite_fault)
    begin
      nxt_dark_cnt = dark_cnt_ff + 32'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dark_cnt_ff <= 32'h0;
    end
    else
    begin
      dark_cnt_ff <= nxt_dark_cnt;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence off_held; !backlight_on_ctrl [*4]; endsequence
  sequence on_held; $rose(backlight_on_ctrl) ##1 backlight_on_ctrl [*3]; endsequence
  sequence lit_steady; lamp_status && $past(lamp_status); endsequence
  // ----
  // Assertions
  // ----
  lamp_stop_a: assert property (off_held |-> !lamp_drive)
    else $error("lamp driven while request low");
  lamp_run_a: assert property (on_held |-> lamp_drive)
    else $error("lamp not driven after request");
  status_rise_a: assert property ($rose(lamp_status) |-> $past(lamp_sense, 2))
    else $error("status rose without lamp current");
  status_drop_a: assert property (off_held |-> !lamp_status)
    else $error("status high with lamp off");
  code_write_a: assert property ($changed(bright_code)
    |-> brightness_bus_data_oe || $past(brightness_bus_data_oe))
    else $error("brightness changed without a bus write");
  full_on_a: assert property (lit_steady and (bright_code == 8'h00
    && $past(bright_code) == 8'h00) |-> lamp_drive)
    else $error("lamp not steady at brightest code");
  step_table_a: assert property ($past(rst_n, 3)
    |-> step_code == STEPS[63 - 8 * int'($past(step_sel)) -: 8])
    else $error("step code differs from table");
  fault_dark_a: assert property (ignite_fault |-> !lamp_drive && !lamp_status)
    else $error("lamp active in fault");
  strike_bound_a: assert property (dark_cnt_ff < STRIKE_MAX)
    else $error("striking ran past its limit");
  strike_early_a: assert property ($rose(ignite_fault) |-> dark_cnt_ff > IGNITE_CYC - 8)
    else $error("fault raised too early");
  burst_gap_a: assert property ($fell(lamp_drive) && lamp_status
    |-> ##[1:BURST_CYC] (lamp_drive || !lamp_status))
    else $error("burst off time too long");
endmodule : pvb_inv_chk
bind pvb_inverter_ctrl pvb_inv_chk #(.IGNITE_CYC(IGNITE_CYC), .BURST_CYC(BURST_CYC)) u_chk (
  .core_clk, .rst_n, .backlight_on_ctrl, .lamp_sense, .brightness_bus_clock,
  .brightness_bus_data_in, .step_sel, .brightness_bus_data_out, .brightness_bus_data_oe,
  .lamp_drive, .lamp_status, .ignite_fault, .step_code, .bright_code);

// ### dv/tb.sv
// Self-checking bench for the backlight inverter controller
`timescale 1ns/1ps
module tb;
  localparam int IGN = 2000; // Shortened striking limit
  localparam int BC = 512; // Shortened burst period
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic lamp_sense = 1'b0;
  logic [2:0] step_sel = 3'h0;
  wire backlight_on_ctrl, brightness_bus_clock, host_pull;
  logic brightness_bus_data_out, brightness_bus_data_oe, lamp_drive, lamp_status, ignite_fault;
  logic [7:0] step_code, bright_code;
  wire brightness_bus_data_in = !(host_pull | brightness_bus_data_oe); // Wired-AND, pull-up
  wire [3:0] ev = {ignite_fault, !lamp_drive && !lamp_status, lamp_status, lamp_drive};
  int errors = 0;
  int n_tests = 0;
  int steps[8] = '{8'hE5, 8'hD1, 8'hC3, 8'hBA, 8'h91, 8'h6C, 8'h44, 8'h00};
  int codes[$] = '{8'h00, 8'hFF}; // Brightness codes to write
  int exp_code = 8'hFF; // Model of the held brightness
  int n, on_n, rises;
  logic [2:0] acks;
  always #10 core_clk = ~core_clk;
  pvb_inverter_ctrl #(.IGNITE_CYC(IGN), .BURST_CYC(BC)) dut (.core_clk, .rst_n,
    .backlight_on_ctrl, .lamp_sense, .brightness_bus_clock, .brightness_bus_data_in,
    .step_sel, .brightness_bus_data_out, .brightness_bus_data_oe, .lamp_drive,
    .lamp_status, .ignite_fault, .step_code, .bright_code);
  pvb_host_model u_host (.core_clk, .sda_wire(brightness_bus_data_in),
    .scl(brightness_bus_clock), .sda_pull(host_pull), .on_req(backlight_on_ctrl));
  // ----
  // Bench tasks
  // ----
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic summarize;
    $display("errors=%0d checks=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Bounded wait; running out is a failure
  task automatic wait_ev(input int k, input int lim, output int c);
    for (c = 0; c < lim && ev[k] !== 1'b1; c++) @(negedge core_clk);
    if (c == lim)
    begin
      errors++;
      summarize();
    end
  endtask : wait_ev
  // On cycles and rising edges over two whole burst periods
  task automatic measure(output int on_c, output int r);
    logic prev;
    prev = lamp_drive;
    on_c = 0;
    r = 0;
    repeat (2 * BC)
    begin
      @(negedge core_clk);
      on_c += (lamp_drive === 1'b1);
      r += (lamp_drive === 1'b1 && prev === 1'b0);
      prev = lamp_drive;
    end
  endtask : measure
  // ----
  // Main sequence
  // ----
  initial
  begin
    void'($urandom(47));
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    check("code_rst", bright_code, 8'hFF);
    check("drive_rst", lamp_drive, 1'b0);
    check("sda_out", brightness_bus_data_out, 1'b0);
    foreach (steps[i])
    begin
      step_sel = 3'(i);
      repeat (2) @(negedge core_clk);
      check("step", step_code, steps[i]);
    end
    $display("test steps done");
    u_host.set_on(1'b1);
    wait_ev(0, 10, n);
    check("drive_on", lamp_drive, 1'b1);
    lamp_sense = 1'b1;
    wait_ev(1, 10, n);
    check("status_on", lamp_status, 1'b1);
    $display("test lamp_on done");
    codes.push_back($urandom_range(8'hFE, 8'h01));
    foreach (codes[i])
    begin
      u_host.write(7'h2C, 8'(codes[i]), acks);
      exp_code = codes[i];
      check("acks", acks, 3'h7);
      check("code", bright_code, exp_code);
      repeat (BC) @(negedge core_clk);
      measure(on_n, rises);
      check("burst_on", on_n, 4 * (256 - exp_code));
      check("burst_rises", rises, (exp_code == 0) ? 0 : 2);
    end
    u_host.write(7'h2D, 8'h33, acks);
    check("acks_bad", acks, 3'h0);
    check("code_bad", bright_code, exp_code);
    $display("test brightness done");
    u_host.set_on(1'b0);
    lamp_sense = 1'b0;
    wait_ev(2, 10, n);
    check("dark", lamp_status, 1'b0);
    repeat (4) @(negedge core_clk);
    u_host.set_on(1'b1);
    wait_ev(3, IGN + 50, n);
    check("fault_late", n >= IGN, 1'b1);
    repeat (20) @(negedge core_clk);
    check("fault_dark", lamp_drive, 1'b0);
    u_host.set_on(1'b0);
    repeat (6) @(negedge core_clk);
    check("fault_clear", ignite_fault, 1'b0);
    $display("test ignition done");
    summarize();
  end
endmodule : tb

// ### hdl/pvb_bus_rx.sv
// Write-only brightness bus receiver: address, command, then data on every later byte
`timescale 1ns/1ps
`include "pvb_defines.svh"
module pvb_bus_rx
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_s, // Synchronised bus clock
  input wire logic sda_s, // Synchronised bus data
  output logic sda_oe, // Pull data low when high
  output logic [7:0] wr_byte, // Last data byte received
  output logic wr_stb // One-cycle pulse with wr_byte
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pvb_pkg::pvb_bus_t st_ff, nxt_st; // Receiver state
  logic scl_d_ff, sda_d_ff; // Previous samples for edges
  logic [7:0] sh_ff, nxt_sh; // Shift register
  logic [3:0] cnt_ff, nxt_cnt; // Bit counter
  logic nbyte_ff, nxt_nbyte; // Second byte seen: next is data
  logic oe_ff, nxt_oe; // Acknowledge drive
  logic [7:0] byte_ff, nxt_byte; // Captured data
  logic stb_ff, nxt_stb; // Capture pulse
  logic scl_rise, scl_fall, start_c, stop_c;

  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_c = scl_s & sda_d_ff & ~sda_s;
  assign stop_c = scl_s & ~sda_d_ff & sda_s;
  assign sda_oe = oe_ff;
  assign wr_byte = byte_ff;
  assign wr_stb = stb_ff;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Bytes: address, command (ignored), then data on any later byte
  always_comb
  begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_nbyte = nbyte_ff;
    nxt_oe = oe_ff;
    nxt_byte = byte_ff;
    nxt_stb = 1'b0;
    if (start_c)
    begin
      // Start or repeated start restarts framing
      nxt_st = pvb_pkg::PVB_ADR;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
      nxt_nbyte = 1'b0;
    end
    else if (stop_c)
    begin
      nxt_st = pvb_pkg::PVB_IDLE;
      nxt_oe = 1'b0;
    end
    else
    begin
      case (st_ff)
        pvb_pkg::PVB_ADR, pvb_pkg::PVB_DAT:
        begin
          if (scl_rise)
          begin
            nxt_sh = {sh_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (scl_fall && cnt_ff == 4'h8)
          begin
            // Address must match and be a write
            if (st_ff == pvb_pkg::PVB_ADR && sh_ff != {`PVB_BUS_ADDR, 1'b0})
              nxt_st = pvb_pkg::PVB_SKIP;
            else
            begin
              nxt_oe = 1'b1;
              nxt_st = (st_ff == pvb_pkg::PVB_ADR) ? pvb_pkg::PVB_AACK
                                                   : pvb_pkg::PVB_DACK;
              if (st_ff == pvb_pkg::PVB_DAT && nbyte_ff)
              begin
                nxt_byte = sh_ff;
                nxt_stb = 1'b1;
              end
            end
          end
        end
        pvb_pkg::PVB_AACK, pvb_pkg::PVB_DACK:
        begin
          // Release after the acknowledge clock
          if (scl_fall)
          begin
            nxt_oe = 1'b0;
            nxt_cnt = 4'h0;
            if (st_ff == pvb_pkg::PVB_DACK)
              nxt_nbyte = 1'b1;
            nxt_st = pvb_pkg::PVB_DAT;
          end
        end
        pvb_pkg::PVB_IDLE, pvb_pkg::PVB_SKIP:
        begin
          nxt_st = st_ff;
        end
        default:
        begin
          nxt_st = pvb_pkg::PVB_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= pvb_pkg::PVB_IDLE;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      sh_ff <= 8'h00;
      cnt_ff <= 4'h0;
      nbyte_ff <= 1'b0;
      oe_ff <= 1'b0;
      byte_ff <= `PVB_CODE_RST;
      stb_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      nbyte_ff <= nxt_nbyte;
      oe_ff <= nxt_oe;
      byte_ff <= nxt_byte;
      stb_ff <= nxt_stb;
    end
  end
endmodule : pvb_bus_rx

// ### hdl/pvb_defines.svh
// Timing and code constants for the panel backlight inverter controller
`ifndef PVB_DEFINES_SVH
`define PVB_DEFINES_SVH
// Clock rate in Hz
`define PVB_CLK_HZ 50000000
// Ignition window maximum, milliseconds
`define PVB_IGNITE_MAX_MS 1400
// Burst dimming frequency bounds, Hz
`define PVB_BURST_MIN_HZ 200
`define PVB_BURST_MAX_HZ 220
// Chosen burst frequency, Hz
`define PVB_BURST_HZ 210
// Brightness code extremes
`define PVB_CODE_DIM 8'hFF
`define PVB_CODE_BRIGHT 8'h00
// Reset brightness code (dimmest)
`define PVB_CODE_RST 8'hFF
// Step table byte offsets
`define PVB_STEP_FIRST 113
`define PVB_STEP_LAST 120
// Step codes, dimmest to brightest
`define PVB_STEP_TABLE {8'hE5, 8'hD1, 8'hC3, 8'hBA, 8'h91, 8'h6C, 8'h44, 8'h00}
// Slave address of the brightness register
`define PVB_BUS_ADDR 7'h2C
`endif

// ### hdl/pvb_inverter_ctrl.sv
// Backlight inverter controller: on/off, lamp status, brightness, burst dimming
`timescale 1ns/1ps
`include "pvb_defines.svh"
// Summary of operation
// - Lamp runs while control input high
// - Status output high from first lamp current until control input drops
// - Brightness byte: FF dimmest, 00 brightest
// - Eight step codes at bytes 113 to 120
// - Shut down if unlit after 1.4 s
// - Burst dimming repeats at 200 to 220 Hz
module pvb_inverter_ctrl
#(
  parameter int CLK_HZ = `PVB_CLK_HZ, // Core clock rate
  parameter int IGNITE_MS = `PVB_IGNITE_MAX_MS, // Striking limit
  parameter int BURST_HZ = `PVB_BURST_HZ, // Burst repeat rate
  parameter int IGNITE_CYC = CLK_HZ / 1000 * IGNITE_MS, // Striking limit, cycles
  parameter int BURST_CYC = CLK_HZ / BURST_HZ // Burst period, cycles
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic backlight_on_ctrl, // Pin: lamp on request
  input wire logic lamp_sense, // Pin: lamp current detected
  input wire logic brightness_bus_clock, // Pin: bus clock
  input wire logic brightness_bus_data_in, // Pin: bus data level
  input wire logic [2:0] step_sel, // Step table index for readback
  output logic brightness_bus_data_out, // Always low when driven
  output logic brightness_bus_data_oe, // High while pulling data low
  output logic lamp_drive, // Lamp oscillator enable
  output logic lamp_status, // Lamp lit feedback
  output logic ignite_fault, // Striking timed out
  output logic [7:0] step_code, // Step code from the table
  output logic [7:0] bright_code // Current brightness code
);
  // ----------------------------------------------------------------
  // Checks and state
  // ----------------------------------------------------------------
  // Parameter limits are refused at elaboration, before any logic is built
  if (BURST_HZ < `PVB_BURST_MIN_HZ || BURST_HZ > `PVB_BURST_MAX_HZ)
  begin : g_burst_range
    $error("burst rate out of range");
  end
  if (BURST_CYC < 256 || IGNITE_CYC < 1)
  begin : g_count_range
    $error("counts too small");
  end

  localparam logic [63:0] STEPS = `PVB_STEP_TABLE; // First byte is dimmest
  localparam logic [31:0] IGN_LIM = 32'(IGNITE_CYC);
  localparam logic [31:0] BUR_LIM = 32'(BURST_CYC);

  pvb_pkg::pvb_lamp_t st_ff, nxt_st; // Lamp state
  logic [1:0] on_sy_ff, sns_sy_ff, scl_sy_ff, sda_sy_ff; // Pin synchronisers
  logic [31:0] ign_ff, nxt_ign; // Striking timer
  logic [31:0] bur_ff, nxt_bur; // Burst period counter
  logic [7:0] br_ff, nxt_br; // Brightness code
  logic drv_ff, nxt_drv; // Lamp drive output
  logic stat_ff, nxt_stat; // Status output
  logic flt_ff, nxt_flt; // Fault output
  logic [7:0] stc_ff, nxt_stc; // Step code output
  logic sda_oe_w; // Receiver acknowledge
  logic [7:0] wr_byte; // Received code
  logic wr_stb; // Received pulse
  logic burst_on; // Inside the on part of a burst

  // Step code lookup, brightest at the last offset
  function automatic logic [7:0] pvb_step(input logic [2:0] idx);
    pvb_step = STEPS[8'(63 - 8 * int'(idx)) -: 8];
  endfunction : pvb_step

  // Burst on-time shrinks as the code rises toward dim
  function automatic logic burst_gate(input logic [31:0] cnt, input logic [7:0] code);
    logic [39:0] lim;
    lim = 40'(BUR_LIM) * 40'(9'h100 - {1'b0, code}) / 40'h100;
    burst_gate = (40'(cnt) < lim) || (code == `PVB_CODE_BRIGHT);
  endfunction : burst_gate

  // ----------------------------------------------------------------
  // Bus receiver
  // ----------------------------------------------------------------
  pvb_bus_rx u_rx
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scl_s(scl_sy_ff[1]),
    .sda_s(sda_sy_ff[1]),
    .sda_oe(sda_oe_w),
    .wr_byte(wr_byte),
    .wr_stb(wr_stb)
  );

  assign brightness_bus_data_out = 1'b0;
  assign brightness_bus_data_oe = sda_oe_w;
  assign lamp_drive = drv_ff;
  assign lamp_status = stat_ff;
  assign ignite_fault = flt_ff;
  assign step_code = stc_ff;
  assign bright_code = br_ff;
  assign burst_on = burst_gate(bur_ff, br_ff);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Dimming: burst counter free-runs, a new code takes effect next cycle
  always_comb
  begin
    nxt_bur = (bur_ff >= BUR_LIM - 32'h1) ? 32'h0 : bur_ff + 32'h1;
    nxt_br = wr_stb ? wr_byte : br_ff;
    nxt_stc = pvb_step(step_sel);
  end

  // Dimming registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bur_ff <= 32'h0;
      br_ff <= `PVB_CODE_RST;
      stc_ff <= 8'h00;
    end
    else
    begin
      bur_ff <= nxt_bur;
      br_ff <= nxt_br;
      stc_ff <= nxt_stc;
    end
  end

  // Fault latches until the control input drops, so a retry needs a toggle
  always_comb
  begin
    nxt_st = st_ff;
    nxt_ign = ign_ff;
    case (st_ff)
      pvb_pkg::PVB_OFF:
      begin
        nxt_ign = 32'h0;
        if (on_sy_ff[1])
          nxt_st = pvb_pkg::PVB_STRIKE;
      end
      pvb_pkg::PVB_STRIKE:
      begin
        nxt_ign = ign_ff + 32'h1;
        if (!on_sy_ff[1])
          nxt_st = pvb_pkg::PVB_OFF;
        else if (sns_sy_ff[1])
          nxt_st = pvb_pkg::PVB_LIT;
        else if (ign_ff >= IGN_LIM - 32'h1)
          nxt_st = pvb_pkg::PVB_FAULT;
      end
      pvb_pkg::PVB_LIT:
      begin
        if (!on_sy_ff[1])
          nxt_st = pvb_pkg::PVB_OFF;
      end
      pvb_pkg::PVB_FAULT:
      begin
        if (!on_sy_ff[1])
          nxt_st = pvb_pkg::PVB_OFF;
      end
      default:
      begin
        nxt_st = pvb_pkg::PVB_OFF;
      end
    endcase
    // Striking runs full power; dimming only once lit
    nxt_drv = (nxt_st == pvb_pkg::PVB_STRIKE)
           || (nxt_st == pvb_pkg::PVB_LIT && burst_on);
    nxt_stat = (nxt_st == pvb_pkg::PVB_LIT);
    nxt_flt = (nxt_st == pvb_pkg::PVB_FAULT);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= pvb_pkg::PVB_OFF;
      ign_ff <= 32'h0;
      drv_ff <= 1'b0;
      stat_ff <= 1'b0;
      flt_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      ign_ff <= nxt_ign;
      drv_ff <= nxt_drv;
      stat_ff <= nxt_stat;
      flt_ff <= nxt_flt;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Two stages per pin; only the second stage is read by any logic
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      on_sy_ff <= 2'h0;
      sns_sy_ff <= 2'h0;
      scl_sy_ff <= 2'h3; // Bus idles high, so no false edge after reset
      sda_sy_ff <= 2'h3;
    end
    else
    begin
      on_sy_ff <= {on_sy_ff[0], backlight_on_ctrl};
      sns_sy_ff <= {sns_sy_ff[0], lamp_sense};
      scl_sy_ff <= {scl_sy_ff[0], brightness_bus_clock};
      sda_sy_ff <= {sda_sy_ff[0], brightness_bus_data_in};
    end
  end
endmodule : pvb_inverter_ctrl

// ### hdl/pvb_pkg.sv
// Types for the panel backlight inverter controller
package pvb_pkg;
  // Lamp control states
  typedef enum logic [1:0] {PVB_OFF, PVB_STRIKE, PVB_LIT, PVB_FAULT} pvb_lamp_t;
  // Brightness bus receiver states
  typedef enum logic [2:0] {PVB_IDLE, PVB_ADR, PVB_AACK, PVB_DAT, PVB_DACK, PVB_SKIP}
    pvb_bus_t;
endpackage : pvb_pkg
